// [fram_host_ctrl.sv]
// Host controller driving a bytewide ferroelectric memory through its pins.
// Assumes the memory sits on the board; data pins split into in/out/enable.
// Contract
// - Host holds strobes low for access time and data stable through setup.
// - Host keeps chip select high at least the minimum pre-charge time.
// - Host never holds chip select low beyond its maximum low time.
// - Host gives every access its own falling chip-select edge.
// - Host keeps chip select high while the supply is below minimum; code gates only the start of an access on supply_ok, not one under way.
// - With chip select tied low, write strobe stays high over power cycles.
`timescale 1ns/1ns
`default_nettype none
module fram_host_ctrl (
  input wire logic mclk,
  input wire logic rst,
  input wire logic supply_ok,
  input wire logic req_valid,
  output logic req_ready,
  input wire fram_host_pkg::mem_req_t req,
  output logic [fram_host_pkg::DATA_W-1:0] rd_data,
  output logic rd_valid,
  output logic [fram_host_pkg::ADDR_W-fram_host_pkg::ROW_LSB-1:0] last_row,
  output logic chip_select_n,
  output logic write_strobe_n,
  output logic output_drive_n,
  output logic [fram_host_pkg::ADDR_W-1:0] address_lines,
  output logic [fram_host_pkg::DATA_W-1:0] data_lines_o,
  output logic data_lines_oe,
  input wire logic [fram_host_pkg::DATA_W-1:0] data_lines_i
);
  import fram_host_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_HOLD = 3'b001,
    ST_ACCESS = 3'b010,
    ST_SAMPLE = 3'b011,
    ST_PRECHARGE = 3'b100
  } state_t;

  ////////////////////////////////////////////////////////////////////////////
  // State and registers
  state_t state_reg, state_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [CNT_W-1:0] low_cnt_reg, low_cnt_next;
  pin_out_t pins_reg, pins_next;
  logic [DATA_W-1:0] rd_data_reg, rd_data_next;
  logic rd_valid_reg, rd_valid_next;
  logic [ADDR_W-ROW_LSB-1:0] row_reg, row_next;
  logic supply_meta_reg, supply_sync_reg;
  logic supply_meta_next, supply_sync_next;
  logic [DATA_W-1:0] data_sync;

  // Cycle count helper, narrowed to counter width
  function automatic logic [CNT_W-1:0] cyc(input int n);
    cyc = CNT_W'(n);
  endfunction

  // Data lines pass two flops before use
  fram_pin_sync u_sync (
    .mclk(mclk),
    .rst(rst),
    .din(data_lines_i),
    .dout(data_sync)
  );

  // Supply-good level synchroniser; first stage read only by the second
  always_comb begin
    supply_meta_next = supply_ok;
    supply_sync_next = supply_meta_reg;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      supply_meta_reg <= 1'b0;
      supply_sync_reg <= 1'b0;
    end else begin
      supply_meta_reg <= supply_meta_next;
      supply_sync_reg <= supply_sync_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Access sequencer
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    pins_next = pins_reg;
    rd_data_next = rd_data_reg;
    rd_valid_next = 1'b0;
    row_next = row_reg;
    low_cnt_next = pins_reg.chip_select_n ? CNT_ZERO : low_cnt_reg + CNT_ONE;
    unique case (state_reg)
      ST_IDLE: begin
        // Start only with supply good; chip select high all the while
        if (req_valid && supply_sync_reg) begin
          pins_next.address_lines = req.addr;
          pins_next.chip_select_n = 1'b0;
          pins_next.write_strobe_n = ~req.write;
          pins_next.output_drive_n = req.write;
          pins_next.data_out = req.wdata;
          pins_next.data_oe = req.write;
          row_next = req.addr[ADDR_W-1:ROW_LSB];
          cnt_next = cyc(HOLD_CYC);
          state_next = ST_HOLD;
        end
      end
      ST_HOLD: begin
        // Address kept stable through hold, then left as is
        cnt_next = cnt_reg - CNT_ONE;
        if (cnt_reg == CNT_ONE) begin
          cnt_next = cyc(ACCESS_CYC + (pins_reg.write_strobe_n ? SYNC_CYC : SETUP_CYC));
          state_next = ST_ACCESS;
        end
      end
      ST_ACCESS: begin
        // Strobes held low at least the access time and data setup
        // Low-time guard leaves room for the sample cycle before select rises
        cnt_next = cnt_reg - CNT_ONE;
        if (cnt_reg == CNT_ONE || low_cnt_reg >= cyc(CS_LOW_MAX_CYC - 2)) begin
          state_next = ST_SAMPLE;
        end
      end
      ST_SAMPLE: begin
        // Write ends on chip select and strobe rising together
        if (!pins_reg.output_drive_n) begin
          rd_data_next = data_sync;
          rd_valid_next = 1'b1;
        end
        pins_next.chip_select_n = 1'b1;
        pins_next.write_strobe_n = 1'b1;
        pins_next.output_drive_n = 1'b1;
        cnt_next = cyc(PRECHARGE_CYC);
        state_next = ST_PRECHARGE;
      end
      ST_PRECHARGE: begin
        // Release data after the write edge, then wait pre-charge
        pins_next.data_oe = 1'b0;
        cnt_next = cnt_reg - CNT_ONE;
        if (cnt_reg == CNT_ONE) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      cnt_reg <= CNT_ZERO;
      low_cnt_reg <= CNT_ZERO;
      pins_reg <= '{chip_select_n: 1'b1, write_strobe_n: 1'b1, output_drive_n: 1'b1,
                   address_lines: 15'h0000, data_out: 8'h00, data_oe: 1'b0};
      rd_data_reg <= 8'h00;
      rd_valid_reg <= 1'b0;
      row_reg <= 12'h000;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      low_cnt_reg <= low_cnt_next;
      pins_reg <= pins_next;
      rd_data_reg <= rd_data_next;
      rd_valid_reg <= rd_valid_next;
      row_reg <= row_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign req_ready = (state_reg == ST_IDLE) && supply_sync_reg;
  assign rd_data = rd_data_reg;
  assign rd_valid = rd_valid_reg;
  assign last_row = row_reg;
  assign chip_select_n = pins_reg.chip_select_n;
  assign write_strobe_n = pins_reg.write_strobe_n;
  assign output_drive_n = pins_reg.output_drive_n;
  assign address_lines = pins_reg.address_lines;
  assign data_lines_o = pins_reg.data_out;
  assign data_lines_oe = pins_reg.data_oe;
endmodule // fram_host_ctrl
`default_nettype wire

// [fram_host_pkg.sv]
// Package for the parallel ferroelectric memory host controller.
// Assumes a 100 MHz mclk; all timing counts derive from that rate.
`default_nettype none
package fram_host_pkg;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int CLK_PERIOD_NS = 10;
  // Access time (least), cycle timing and pre-charge in ns
  localparam int ACCESS_TIME_NS = 70;
  localparam int PRECHARGE_MIN_TIME_NS = 60;
  localparam int CS_LOW_MAX_NS = 10000;
  localparam int DATA_SETUP_NS = 30;
  localparam int ADDR_HOLD_NS = 10;
  // Cycle counts: least times round up, longest rounds down
  localparam int ACCESS_CYC = (ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PRECHARGE_CYC = (PRECHARGE_MIN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETUP_CYC = (DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC = (ADDR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CS_LOW_MAX_CYC = CS_LOW_MAX_NS / CLK_PERIOD_NS;
  // Extra read cycles spent in the data-line synchroniser
  localparam int SYNC_CYC = 2;
  // Counter wide enough to hold the longest select-low count
  localparam int CNT_W = 10;
  localparam logic [CNT_W-1:0] CNT_ZERO = 10'h000;
  localparam logic [CNT_W-1:0] CNT_ONE = 10'h001;
  // Row grouping: 8-byte rows, row index is address above bit 2
  localparam int ROW_LSB = 3;

  // Host request carried into the controller
  typedef struct packed {
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } mem_req_t;

  // Pin bundle driven toward the device
  typedef struct packed {
    logic chip_select_n;
    logic write_strobe_n;
    logic output_drive_n;
    logic [ADDR_W-1:0] address_lines;
    logic [DATA_W-1:0] data_out;
    logic data_oe;
  } pin_out_t;
endpackage : fram_host_pkg
`default_nettype wire

// [fram_pin_sync.sv]
// Two-flop synchroniser for the incoming data lines.
// Assumes the device drives data asynchronously to mclk.
`timescale 1ns/1ns
`default_nettype none
module fram_pin_sync (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [fram_host_pkg::DATA_W-1:0] din,
  output logic [fram_host_pkg::DATA_W-1:0] dout
);
  import fram_host_pkg::*;
  logic [DATA_W-1:0] meta_reg;
  logic [DATA_W-1:0] meta_next;
  logic [DATA_W-1:0] sync_reg;
  logic [DATA_W-1:0] sync_next;

  // First stage read only by the second
  always_comb begin
    meta_next = din;
    sync_next = meta_reg;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      meta_reg <= 8'h00;
      sync_reg <= 8'h00;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign dout = sync_reg;
endmodule // fram_pin_sync
`default_nettype wire

// [fram_host_ctrl_properties.sv]
// Pin timing checker for the memory port host controller.
// Assumes the bind below attaches it to the controller.
`timescale 1ns/1ns
`default_nettype none
module fram_host_ctrl_properties (
  input wire logic mclk,
  input wire logic rst,
  input wire logic supply_ok,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic chip_select_n,
  input wire logic write_strobe_n,
  input wire logic output_drive_n,
  input wire logic [fram_host_pkg::ADDR_W-1:0] address_lines,
  input wire logic [fram_host_pkg::DATA_W-1:0] data_lines_o,
  input wire logic data_lines_oe
);
  import fram_host_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////
  // Host side cycle shape
  chk_precharge_min: assert property ($rose(chip_select_n) |-> chip_select_n[*6])
    else $error("select high time too short");
  chk_access_time: assert property ($fell(chip_select_n) |-> (!chip_select_n)[*7])
    else $error("select low time too short");
  chk_cs_low_max: assert property ($fell(chip_select_n) |-> ##[1:1000] chip_select_n)
    else $error("select held low too long");
  chk_wdata_stable: assert property (!write_strobe_n && $past(!write_strobe_n)
    |-> $stable(data_lines_o))
    else $error("write data moved");
  chk_read_release: assert property (!output_drive_n |-> !data_lines_oe)
    else $error("host drives during read");
  chk_strobe_no_drive: assert property (!write_strobe_n |-> output_drive_n)
    else $error("strobe and output drive both low");
  chk_own_select: assert property (req_valid && req_ready |-> ##[1:2] $fell(chip_select_n))
    else $error("access without select fall");
  chk_supply_gate: assert property (req_ready |-> $past(supply_ok, 2))
    else $error("ready with supply low");
  chk_addr_hold: assert property ($fell(chip_select_n) |=> $stable(address_lines))
    else $error("address moved in hold");
  // Main scenarios
  cov_read: cover property ($fell(chip_select_n) && write_strobe_n);
  cov_write: cover property ($fell(chip_select_n) && !write_strobe_n);
  cov_supply: cover property ($fell(supply_ok));
endmodule // fram_host_ctrl_properties
bind fram_host_ctrl fram_host_ctrl_properties i_fram_host_ctrl_properties (
  .mclk(mclk), .rst(rst), .supply_ok(supply_ok), .req_valid(req_valid),
  .req_ready(req_ready), .chip_select_n(chip_select_n), .write_strobe_n(write_strobe_n),
  .output_drive_n(output_drive_n), .address_lines(address_lines),
  .data_lines_o(data_lines_o), .data_lines_oe(data_lines_oe));
`default_nettype wire

// [fram_dev_model.sv]
// Behavioural model of the bytewide memory on the far side.
// Assumes the bench resolves the shared data lines.
`timescale 1ns/1ns
`default_nettype none
module fram_dev_model (
  input wire logic chip_select_n,
  input wire logic write_strobe_n,
  input wire logic output_drive_n,
  input wire logic [fram_host_pkg::ADDR_W-1:0] address_lines,
  input wire logic [fram_host_pkg::DATA_W-1:0] data_lines,
  output logic [fram_host_pkg::DATA_W-1:0] dev_data,
  output logic dev_oe
);
  import fram_host_pkg::*;
  logic [DATA_W-1:0] cells [0:(1<<ADDR_W)-1];
  logic [ADDR_W-1:0] held_addr = '0;
  logic writing = 1'b0;
  logic data_ready = 1'b0;
  // Select fall latches address and kind; no supply gate
  always @(negedge chip_select_n) begin
    held_addr = address_lines;
    writing = !write_strobe_n;
    data_ready = 1'b0;
    #(ACCESS_TIME_NS) data_ready = 1'b1;
  end
  // Late strobe turns a read into a write
  always @(negedge write_strobe_n) begin
    if (!chip_select_n) writing = 1'b1;
  end
  // First rising edge ends the write; select rise starts pre-charge, no busy
  always @(posedge chip_select_n or posedge write_strobe_n) begin
    if (writing) cells[held_addr] = data_lines;
    writing = 1'b0;
    if (chip_select_n) data_ready = 1'b0;
  end
  // Drive only once data is valid and output drive is low
  assign dev_oe = !chip_select_n && !output_drive_n && !writing && data_ready;
  assign dev_data = cells[held_addr];
endmodule // fram_dev_model
`default_nettype wire

// [tb_top.sv]
// Self-checking bench: host controller against the memory model.
// Assumes the package constants and a 100 MHz clock.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import fram_host_pkg::*;
  typedef struct packed {logic [7:0] d; logic [11:0] row;} exp_t;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic supply_ok = 1'b1;
  logic req_valid = 1'b0;
  mem_req_t req = '0;
  logic req_ready, rd_valid, chip_select_n, write_strobe_n, output_drive_n;
  logic data_lines_oe, dev_oe;
  logic [7:0] rd_data, data_lines_o, dev_data, data_lines;
  logic [7:0] idle_pat = 8'h00;
  logic [11:0] last_row;
  logic [14:0] address_lines;
  logic [7:0] shadow [logic [14:0]];
  logic [14:0] edge_a [4] = '{15'h0000, 15'h0007, 15'h0008, 15'h7FFF};
  exp_t expq[$];
  exp_t e;
  int bad_count = 0;
  int tests_run = 0;
  ////////////////////////////////////////////////////////////////////
  // Clock, released bus pattern and wire resolution
  initial begin
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) idle_pat <= ~idle_pat + 8'h3D;
  assign data_lines = data_lines_oe ? data_lines_o : (dev_oe ? dev_data : idle_pat);
  fram_host_ctrl i_fram_host_ctrl (.mclk(mclk), .rst(rst), .supply_ok(supply_ok),
    .req_valid(req_valid), .req_ready(req_ready), .req(req), .rd_data(rd_data),
    .rd_valid(rd_valid), .last_row(last_row), .chip_select_n(chip_select_n),
    .write_strobe_n(write_strobe_n), .output_drive_n(output_drive_n),
    .address_lines(address_lines), .data_lines_o(data_lines_o),
    .data_lines_oe(data_lines_oe), .data_lines_i(data_lines));
  fram_dev_model i_fram_dev_model (.chip_select_n(chip_select_n),
    .write_strobe_n(write_strobe_n), .output_drive_n(output_drive_n),
    .address_lines(address_lines), .data_lines(data_lines), .dev_data(dev_data),
    .dev_oe(dev_oe));
  ////////////////////////////////////////////////////////////////////
  // Compare, verdict, request and drain
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wait_ok(input logic idle_too);
    int n;
    n = 0;
    while (req_ready !== 1'b1 || (idle_too && expq.size() != 0)) begin
      n++;
      if (n > 300) begin
        bad_count++;
        complete_run();
      end
      @(posedge mclk);
    end
  endtask
  task automatic access(input logic w, input logic [14:0] a, input logic [7:0] d);
    req_valid <= 1'b1;
    req <= '{w, a, d};
    @(posedge mclk);
    wait_ok(1'b0);
    req_valid <= 1'b0;
    @(posedge mclk);
    if (w) shadow[a] = d;
    else expq.push_back('{shadow[a], a[14:3]});
  endtask
  // Each read answer is taken against the oldest note
  always @(posedge mclk) begin
    if (rd_valid === 1'b1) begin
      if (expq.size() == 0) check("rd_extra", 16'h0001, 16'h0000);
      else begin
        e = expq.pop_front();
        check("rd_data", 16'(rd_data), 16'(e.d));
        check("last_row", 16'(last_row), 16'(e.row));
      end
    end
  end
  ////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    int unsigned s;
    logic [14:0] a;
    s = $urandom(32'hF1C7);
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    for (int i = 0; i < 12; i++) begin
      a = 15'($urandom());
      access(1'b1, a, 8'($urandom()));
      access(1'b0, a, 8'h00);
    end
    for (int k = 0; k < 8; k++) access(k < 4, edge_a[k % 4], 8'(k) ^ 8'hC3);
    wait_ok(1'b1);
    $display("test random_and_rows done");
    supply_ok <= 1'b0;
    repeat (3) @(posedge mclk);
    req_valid <= 1'b1;
    repeat (20) begin
      @(posedge mclk);
      check("cs_ready_low_supply", {14'h0, chip_select_n, req_ready}, 16'h0002);
    end
    req_valid <= 1'b0;
    supply_ok <= 1'b1;
    @(posedge mclk);
    access(1'b0, edge_a[3], 8'h00);
    wait_ok(1'b1);
    $display("test supply_drop done");
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    check("reset_pins", {12'h0, chip_select_n, write_strobe_n, output_drive_n,
      data_lines_oe}, 16'h000E);
    rst <= 1'b0;
    access(1'b1, 15'h1234, 8'h5A);
    access(1'b0, 15'h1234, 8'h00);
    wait_ok(1'b1);
    $display("test mid_reset done");
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
